// *** rtl/pmd_pkg.sv ***
`default_nettype none
package pmd_pkg;
  // data and address widths
  localparam int DATA_W = 24; // data word
  localparam int PTR_W = 16; // pointer and offset registers
  localparam int EXT_W = 8; // accumulator extension part
  localparam int ADDR_W = 8; // apb byte address width
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00; // control, bit0 enable
  localparam logic [7:0] OFF_STATUS = 8'h04; // sticky events, write one to clear
  localparam logic [7:0] OFF_MASK = 8'h08; // interrupt mask
  localparam logic [7:0] OFF_CCR = 8'h0c; // condition code, bit0 limit
  localparam logic [7:0] OFF_VIEW_SEL = 8'h10; // register view select code
  localparam logic [7:0] OFF_VIEW_DATA = 8'h14; // register view data, read only
  localparam logic [7:0] OFF_COUNT = 8'h18; // completed instruction count
  // status bit positions
  localparam int ST_LIMIT = 0; // limiting occurred
  localparam int ST_ILLEGAL = 1; // illegal move field
  localparam int ST_DONE = 2; // instruction completed
  localparam int STAT_W = 3; // status width
  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0001; // enabled after reset
  localparam logic [STAT_W-1:0] RST_STATUS = 3'h0; // no events
  localparam logic [STAT_W-1:0] RST_MASK = 3'h0; // all masked
  localparam logic [4:0] RST_VIEW_SEL = 5'h04; // first input register
  // effective address modes
  localparam logic [2:0] EA_POSTDEC_OFS = 3'h0; // post-decrement by offset
  localparam logic [2:0] EA_POSTINC_OFS = 3'h1; // post-increment by offset
  localparam logic [2:0] EA_POSTDEC = 3'h2; // post-decrement by one
  localparam logic [2:0] EA_POSTINC = 3'h3; // post-increment by one
  localparam logic [2:0] EA_NO_UPD = 3'h4; // no update
  localparam logic [2:0] EA_INDEXED = 3'h5; // pointer plus offset
  localparam logic [2:0] EA_SPECIAL = 3'h6; // absolute or immediate
  localparam logic [2:0] EA_PREDEC = 3'h7; // pre-decrement
  localparam logic [2:0] EA_ABS_REG = 3'h0; // register bits for absolute address
  localparam logic [2:0] EA_IMM_REG = 3'h4; // register bits for immediate data
  // register select codes
  localparam logic [4:0] RS_INPUT_ONE_LOW = 5'h04; // first input register
  localparam logic [4:0] RS_INPUT_TWO_LOW = 5'h06; // third input register
  localparam logic [4:0] RS_SUM_ONE = 5'h0e; // whole first accumulator
  // saturation constants
  localparam logic [23:0] SAT_POS = 24'h7f_ffff; // positive limit
  localparam logic [23:0] SAT_NEG = 24'h80_0000; // negative limit
  // move field kinds
  typedef enum logic [2:0] {
    MV_NONE,
    MV_Y_SINGLE,
    MV_X_REG,
    MV_REG_Y,
    MV_CLASS2
  } move_kind_e;
endpackage
`default_nettype wire

// *** rtl/parallel_move_decoder.sv ***
// Notes on behaviour
// - six-bit address field: mode plus pointer
// - absolute or immediate codes fetch extension word
// - second-space move reads, writes, every mode
// - short form: six-bit address in opcode
// - five-bit register select code map
// - same register may serve as several sources
// - 24-bit into 16-bit keeps low bits
// - 16-bit into 24-bit clears upper byte
// - pointer/offset move result delayed one instruction
// - whole accumulator load sign-extends, clears lower
// - whole accumulator source saturates when overflowing
// - limit flag set when limiting occurred
// - first-space class I field layout
// - class I copies accumulator into input register
// - class II stores accumulator, loads it from an input register
// - class II rejects absolute and immediate modes
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module parallel_move_decoder
  import pmd_pkg::*;
(
  input wire logic mclk_in, // core clock
  input wire logic rst_in, // async reset, active high
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [ADDR_W-1:0] paddr_in, // apb address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error
  input wire logic instr_valid_in, // program word offered
  input wire logic [DATA_W-1:0] instr_in, // program word
  output logic instr_ready_out, // program word taken
  output logic mem_req_out, // data memory request
  output logic mem_space_out, // 0 first space, 1 second space
  output logic [PTR_W-1:0] mem_addr_out, // data memory address
  output logic mem_we_out, // data memory write
  output logic [DATA_W-1:0] mem_wdata_out, // data memory write data
  input wire logic mem_ack_in, // data memory done
  input wire logic [DATA_W-1:0] mem_rdata_in, // data memory read data
  output logic limit_flag_out, // limit condition code
  output logic done_out, // instruction completed pulse
  output logic irq_out // interrupt level
);
  typedef enum logic [1:0] {ST_FETCH, ST_EXT, ST_EXEC, ST_MEM} state_e;
  state_e state; // sequencer state
  state_e next_state; // next sequencer state
  logic [DATA_W-1:0] opword; // latched opcode word
  logic [DATA_W-1:0] extword; // latched extension word
  logic [DATA_W-1:0] in_reg [0:3]; // input registers
  logic [EXT_W-1:0] acc_ext [0:1]; // accumulator extension parts
  logic [DATA_W-1:0] acc_mid [0:1]; // accumulator middle parts
  logic [DATA_W-1:0] acc_low [0:1]; // accumulator lower parts
  logic [PTR_W-1:0] ptr [0:7]; // pointer registers
  logic [PTR_W-1:0] ofs [0:7]; // offset registers
  logic pend_valid; // deferred pointer or offset write
  logic pend_is_ofs; // deferred target is offset bank
  logic [2:0] pend_idx; // deferred target index
  logic [PTR_W-1:0] pend_val; // deferred value
  logic mem_rd; // pending memory access is a read
  logic [4:0] mem_code_q; // destination of memory read
  logic ctrl_en; // software enable
  logic [STAT_W-1:0] status; // sticky events
  logic [STAT_W-1:0] mask; // interrupt mask
  logic [4:0] view_sel; // register view select
  logic [31:0] count; // completed instructions
  // decode results
  move_kind_e kind; // move field kind
  logic [2:0] mode; // address mode bits
  logic [2:0] rrr; // pointer number
  logic uses_ea; // field carries an effective address
  logic [PTR_W-1:0] ea_addr; // effective address
  logic [PTR_W-1:0] ea_new; // updated pointer value
  logic ea_upd; // pointer is updated
  logic [4:0] mem_code; // memory-side register code
  logic dir_rd; // memory to register
  logic rr_valid; // register to register move present
  logic [4:0] rr_src; // register move source
  logic [4:0] rr_dst; // register move destination
  logic space; // memory space
  logic is_imm; // immediate data
  logic illegal; // unusable field
  logic use_mem; // memory access needed
  logic [24:0] mem_src; // limit bit and memory write data
  logic [24:0] rr_val; // limit bit and register move data
  logic [24:0] view_val; // limit bit and register view data
  logic fin; // instruction completes this cycle
  logic lim_event; // limiting happened this cycle
  logic accept; // program word taken
  logic apb_wr; // apb write completes
  logic [31:0] next_rdata; // apb read mux

  // does an opcode word need an extension word
  function automatic logic need_ext(input logic [DATA_W-1:0] w);
    logic ea_form;
    ea_form = ((w[23:22] == 2'b01) && w[19] && w[14]) || (w[23:20] == 4'h1);
    need_ext = ea_form && (w[13:11] == EA_SPECIAL) && ((w[10:8] == EA_ABS_REG) || (w[10:8] == EA_IMM_REG));
  endfunction

  // register read, with limiting of whole accumulators
  function automatic logic [24:0] read_src(input logic [4:0] code);
    logic [EXT_W-1:0] ex;
    logic [DATA_W-1:0] md;
    ex = acc_ext[code[0]];
    md = acc_mid[code[0]];
    read_src = {1'b0, 24'h00_0000};
    case (code[4:3])
      2'b00: read_src = {1'b0, in_reg[code[1:0]]};
      2'b01: begin
        case (code[2:1])
          2'b00: read_src = {1'b0, acc_low[code[0]]};
          2'b01: read_src = {1'b0, {16{ex[7]}}, ex};
          2'b10: read_src = {1'b0, md};
          default: begin
            if (ex != {EXT_W{md[23]}}) begin
              read_src = {1'b1, ex[7] ? SAT_NEG : SAT_POS};
            end else begin
              read_src = {1'b0, md};
            end
          end
        endcase
      end
      2'b10: read_src = {1'b0, 8'h00, ptr[code[2:0]]};
      default: read_src = {1'b0, 8'h00, ofs[code[2:0]]};
    endcase
  endfunction

  // register write; pointer and offset writes are deferred
  task automatic put_dst(input logic [4:0] code, input logic [DATA_W-1:0] val);
    case (code[4:3])
      2'b00: in_reg[code[1:0]] <= val;
      2'b01: begin
        case (code[2:1])
          2'b00: acc_low[code[0]] <= val;
          2'b01: acc_ext[code[0]] <= val[EXT_W-1:0];
          2'b10: acc_mid[code[0]] <= val;
          default: begin
            acc_ext[code[0]] <= {EXT_W{val[23]}};
            acc_mid[code[0]] <= val;
            acc_low[code[0]] <= 24'h00_0000;
          end
        endcase
      end
      default: begin
        pend_valid <= 1'b1;
        pend_is_ofs <= code[3];
        pend_idx <= code[2:0];
        pend_val <= val[PTR_W-1:0];
      end
    endcase
  endtask

  // decode of the latched move field
  always_comb begin
    kind = MV_NONE;
    mode = opword[13:11];
    rrr = opword[10:8];
    uses_ea = 1'b1;
    mem_code = {opword[21:20], opword[18:16]};
    dir_rd = opword[15];
    rr_valid = 1'b0;
    rr_src = RS_SUM_ONE;
    rr_dst = RS_INPUT_ONE_LOW;
    space = 1'b1;
    if ((opword[23:22] == 2'b01) && opword[19]) begin
      kind = MV_Y_SINGLE;
      uses_ea = opword[14];
    end else if ((opword[23:20] == 4'h1) && !opword[14]) begin
      kind = MV_X_REG;
      space = 1'b0;
      mem_code = opword[19] ? {4'h7, opword[18]} : {4'h2, opword[18]};
      rr_valid = 1'b1;
      rr_src = {4'h7, opword[17]};
      rr_dst = {4'h3, opword[16]};
    end else if (opword[23:20] == 4'h1) begin
      kind = MV_REG_Y;
      mem_code = opword[19] ? {4'h7, opword[18]} : {4'h3, opword[18]};
      rr_valid = 1'b1;
      rr_src = {4'h7, opword[17]};
      rr_dst = {4'h2, opword[16]};
    end else if ((opword[23:17] == 7'h04) && !opword[14]) begin
      kind = MV_CLASS2;
      space = opword[15];
      dir_rd = 1'b0;
      mem_code = {4'h7, opword[16]};
      rr_valid = 1'b1;
      rr_src = opword[15] ? RS_INPUT_TWO_LOW : RS_INPUT_ONE_LOW;
      rr_dst = {4'h7, opword[16]};
    end else begin
      uses_ea = 1'b0;
    end
    is_imm = uses_ea && (mode == EA_SPECIAL) && (rrr == EA_IMM_REG);
    illegal = (kind == MV_Y_SINGLE) && (mem_code[4:2] == 3'h0);
    if (uses_ea && (mode == EA_SPECIAL) && (rrr != EA_ABS_REG) && (rrr != EA_IMM_REG)) begin
      illegal = 1'b1;
    end
    if (is_imm && !dir_rd) begin
      illegal = 1'b1;
    end
    if ((kind == MV_CLASS2) && (mode == EA_SPECIAL)) begin
      illegal = 1'b1;
    end
    use_mem = (kind != MV_NONE) && !illegal && !is_imm;
  end

  always_comb begin
    ea_addr = ptr[rrr];
    ea_new = ptr[rrr];
    ea_upd = 1'b1;
    case (mode)
      EA_POSTDEC_OFS: ea_new = ptr[rrr] - ofs[rrr];
      EA_POSTINC_OFS: ea_new = ptr[rrr] + ofs[rrr];
      EA_POSTDEC: ea_new = ptr[rrr] - 16'h0001;
      EA_POSTINC: ea_new = ptr[rrr] + 16'h0001;
      EA_INDEXED: begin
        ea_addr = ptr[rrr] + ofs[rrr];
        ea_upd = 1'b0;
      end
      EA_PREDEC: begin
        ea_addr = ptr[rrr] - 16'h0001;
        ea_new = ptr[rrr] - 16'h0001;
      end
      EA_SPECIAL: begin
        ea_addr = extword[PTR_W-1:0];
        ea_upd = 1'b0;
      end
      default: ea_upd = 1'b0;
    endcase
    if (!uses_ea) begin
      ea_addr = {10'h000, opword[13:8]};
      ea_upd = 1'b0;
    end
  end

  // sources read from one snapshot
  // a process, so that any change of the register file re-evaluates the reads
  always_comb begin
    mem_src = read_src(mem_code);
    rr_val = read_src(rr_src);
    view_val = read_src(view_sel);
  end
  assign accept = instr_valid_in && instr_ready_out;
  assign fin = ((state == ST_EXEC) && !use_mem) || ((state == ST_MEM) && mem_ack_in);
  assign lim_event = (state == ST_EXEC) && !illegal && (kind != MV_NONE) &&
                     ((use_mem && !dir_rd && mem_src[24]) || (rr_valid && rr_val[24]));
  assign apb_wr = psel_in && penable_in && pready_out && pwrite_in;

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_FETCH: begin
        if (accept) begin
          next_state = need_ext(instr_in) ? ST_EXT : ST_EXEC;
        end
      end
      ST_EXT: next_state = accept ? ST_EXEC : ST_EXT;
      ST_EXEC: next_state = use_mem ? ST_MEM : ST_FETCH;
      ST_MEM: next_state = mem_ack_in ? ST_FETCH : ST_MEM;
      default: next_state = ST_FETCH;
    endcase
  end

  // sequencer state and program words
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_FETCH;
      opword <= 24'h00_0000;
      extword <= 24'h00_0000;
      instr_ready_out <= 1'b0;
    end else begin
      state <= next_state;
      if (accept && (state == ST_FETCH)) begin
        opword <= instr_in;
      end
      if (accept && (state == ST_EXT)) begin
        extword <= instr_in;
      end
      // stall the stream while a move executes or when disabled
      instr_ready_out <= ctrl_en && ((next_state == ST_FETCH) || (next_state == ST_EXT));
    end
  end

  // data memory request
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_req_out <= 1'b0;
      mem_space_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      mem_we_out <= 1'b0;
      mem_wdata_out <= 24'h00_0000;
      mem_rd <= 1'b0;
      mem_code_q <= 5'h00;
    end else if ((state == ST_EXEC) && use_mem) begin
      mem_req_out <= 1'b1;
      mem_space_out <= space;
      mem_addr_out <= ea_addr;
      mem_we_out <= !dir_rd;
      mem_wdata_out <= mem_src[23:0];
      mem_rd <= dir_rd;
      mem_code_q <= mem_code;
    end else if ((state == ST_MEM) && mem_ack_in) begin
      // request held until acknowledged
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
    end
  end

  // data unit and address register file
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        in_reg[i] <= 24'h00_0000;
      end
      for (int i = 0; i < 2; i++) begin
        acc_ext[i] <= 8'h00;
        acc_mid[i] <= 24'h00_0000;
        acc_low[i] <= 24'h00_0000;
      end
      for (int i = 0; i < 8; i++) begin
        ptr[i] <= 16'h0000;
        ofs[i] <= 16'h0000;
      end
      pend_valid <= 1'b0;
      pend_is_ofs <= 1'b0;
      pend_idx <= 3'h0;
      pend_val <= 16'h0000;
    end else begin
      // deferred write lands after the next instruction
      if (fin && pend_valid) begin
        pend_valid <= 1'b0;
        if (pend_is_ofs) begin
          ofs[pend_idx] <= pend_val;
        end else begin
          ptr[pend_idx] <= pend_val;
        end
      end
      if ((state == ST_EXEC) && !illegal && (kind != MV_NONE)) begin
        if (uses_ea && ea_upd) begin
          ptr[rrr] <= ea_new;
        end
        if (rr_valid) begin
          put_dst(rr_dst, rr_val[23:0]);
        end
        if (is_imm) begin
          put_dst(mem_code, extword);
        end
      end
      if ((state == ST_MEM) && mem_ack_in && mem_rd) begin
        put_dst(mem_code_q, mem_rdata_in);
      end
    end
  end

  // completion pulse and counter
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      count <= 32'h0000_0000;
    end else begin
      done_out <= fin;
      if (fin) begin
        count <= count + 32'h0000_0001;
      end
    end
  end

  // limit flag, sticky; an event wins over a software clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      limit_flag_out <= 1'b0;
    end else if (lim_event) begin
      limit_flag_out <= 1'b1;
    end else if (apb_wr && (paddr_in == OFF_CCR)) begin
      limit_flag_out <= pwdata_in[0];
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status <= RST_STATUS;
      mask <= RST_MASK;
      irq_out <= 1'b0;
    end else begin
      status <= (status & ~((apb_wr && (paddr_in == OFF_STATUS)) ? pwdata_in[STAT_W-1:0] : 3'h0)) |
                {fin, (state == ST_EXEC) && illegal, lim_event};
      if (apb_wr && (paddr_in == OFF_MASK)) begin
        mask <= pwdata_in[STAT_W-1:0];
      end
      irq_out <= |(status & mask);
    end
  end

  // software control registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_en <= RST_CTRL[0];
      view_sel <= RST_VIEW_SEL;
    end else if (apb_wr && (paddr_in == OFF_CTRL)) begin
      ctrl_en <= pwdata_in[0];
    end else if (apb_wr && (paddr_in == OFF_VIEW_SEL)) begin
      view_sel <= pwdata_in[4:0];
    end
  end

  // apb read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr_in)
      OFF_CTRL: next_rdata = {31'h0000_0000, ctrl_en};
      OFF_STATUS: next_rdata = {29'h0000_0000, status};
      OFF_MASK: next_rdata = {29'h0000_0000, mask};
      OFF_CCR: next_rdata = {31'h0000_0000, limit_flag_out};
      OFF_VIEW_SEL: next_rdata = {27'h000_0000, view_sel};
      OFF_VIEW_DATA: next_rdata = {8'h00, view_val[23:0]};
      OFF_COUNT: next_rdata = count;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // apb handshake: one wait state
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && (paddr_in > OFF_COUNT || paddr_in[1:0] != 2'h0);
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        prdata_out <= next_rdata;
      end
    end
  end

  chk_ext_word_fetch: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_FETCH && accept && need_ext(instr_in)) |=> (state == ST_EXT) && !fin)
    else $error("extension word not awaited");
  chk_ea_predec: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_EXEC && uses_ea && mode == EA_PREDEC && use_mem) |=>
      mem_req_out && (mem_addr_out == $past(ptr[rrr]) - 16'h0001))
    else $error("pre-decrement address wrong");
  chk_abs_short: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_EXEC && kind == MV_Y_SINGLE && !uses_ea && use_mem) |=>
      mem_space_out && (mem_addr_out == {10'h000, $past(opword[13:8])}) ##1 state != ST_EXT)
    else $error("short address wrong");
  chk_trunc_low: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_MEM && mem_ack_in && mem_rd && mem_code_q[4]) |=>
      pend_valid && (pend_val == $past(mem_rdata_in[15:0])))
    else $error("pointer load not truncated");
  // upper byte zero for narrow source
  chk_zero_fill: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_EXEC && use_mem && !dir_rd && mem_code[4]) |=> mem_we_out && (mem_wdata_out[23:16] == 8'h00))
    else $error("upper byte not cleared");
  chk_ptr_delay: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pend_valid && !fin) |=> pend_valid && $stable(pend_val))
    else $error("deferred pointer value lost");
  chk_acc_load: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_MEM && mem_ack_in && mem_rd && mem_code_q == RS_SUM_ONE) |=>
      (acc_low[0] == 24'h00_0000) && (acc_ext[0] == {8{acc_mid[0][23]}}) && (acc_mid[0] == $past(mem_rdata_in)))
    else $error("accumulator load not extended");
  chk_sat_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_EXEC && use_mem && !dir_rd && mem_src[24]) |=>
      (mem_wdata_out == SAT_POS) || (mem_wdata_out == SAT_NEG))
    else $error("limited store not saturated");
  chk_limit_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    lim_event |=> limit_flag_out && status[ST_LIMIT] ##1 limit_flag_out || $past(apb_wr))
    else $error("limit flag not set");
  chk_class2_mode: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_EXEC && kind == MV_CLASS2 && mode == EA_SPECIAL) |=> !mem_req_out && status[ST_ILLEGAL])
    else $error("class II special mode accepted");
endmodule
`default_nettype wire

// *** verif/prog_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
// program store and data memory beside the decoder
module prog_mem (
  input wire logic clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic ready_in, // word taken
  output logic valid_out, // word offered
  output logic [23:0] word_out, // program word
  input wire logic req_in, // data request
  input wire logic we_in, // data write
  input wire logic [15:0] addr_in, // data address
  input wire logic [23:0] wdata_in, // write data
  output logic ack_out, // data done
  output logic [23:0] rdata_out // read data
);
  logic [23:0] mem [32]; // program words
  logic [23:0] dmem [64]; // data words
  int pc; // next word offered
  int top = 0; // words loaded so far
  assign valid_out = pc < top;
  // idle stream shows a changed word, never the last one
  assign word_out = valid_out ? mem[pc] : ~mem[pc-1];
  // read data only meaningful with ack
  assign rdata_out = ack_out ? dmem[addr_in[5:0]] : ~dmem[addr_in[5:0]];
  // step through the stream on each taken word
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) pc <= 0;
    else if (valid_out && ready_in) pc <= pc + 1;
  end
  // answer one cycle after a request, write at the ack edge
  // plain process: the bench preloads data words directly
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) ack_out <= 1'b0;
    else ack_out <= req_in && !ack_out;
    if (!rst_in && req_in && ack_out && we_in) dmem[addr_in[5:0]] <= wdata_in;
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pmd_pkg::*;
  logic mclk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [7:0] paddr = 0; // apb address
  logic [31:0] pwdata = 0, prdata, q; // apb data
  logic iv, ir, mreq, msp, mwe, mack, limit, done, irq; // stream, memory, flags
  logic [23:0] iw, mwd, mrd; // words
  logic [15:0] ma; // data address
  int errors = 0, n_tests = 0;
  parallel_move_decoder parallel_move_decoder_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .instr_valid_in(iv),
    .instr_in(iw), .instr_ready_out(ir), .mem_req_out(mreq), .mem_space_out(msp), .mem_addr_out(ma),
    .mem_we_out(mwe), .mem_wdata_out(mwd), .mem_ack_in(mack), .mem_rdata_in(mrd),
    .limit_flag_out(limit), .done_out(done), .irq_out(irq));
  prog_mem prog_mem_inst (.clk_in(mclk_in), .rst_in(rst_in), .ready_in(ir), .valid_out(iv),
    .word_out(iw), .req_in(mreq), .we_in(mwe), .addr_in(ma), .wdata_in(mwd), .ack_out(mack),
    .rdata_out(mrd));
  initial forever #5 mclk_in = ~mclk_in;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check(n < 20, 1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk_in);
  endtask
  // view one register through the select and data pair
  task automatic view(input logic [4:0] c, input logic [31:0] exp);
    apb(1, OFF_VIEW_SEL, {27'h0, c});
    apb(0, OFF_VIEW_DATA, 0);
    check(q, exp);
  endtask
  function automatic logic [23:0] fy(input logic [4:0] c, input logic w, input logic [5:0] ea);
    return {2'b01, c[4:3], 1'b1, c[2:0], w, 1'b1, ea, 8'h00};
  endfunction
  task automatic run(input logic [23:0] w0, input logic [23:0] w1, input logic two);
    int n;
    n = 0;
    prog_mem_inst.mem[prog_mem_inst.top] = w0;
    prog_mem_inst.mem[prog_mem_inst.top + 1] = w1;
    prog_mem_inst.top <= prog_mem_inst.top + 1 + two;
    do begin
      @(posedge mclk_in);
      n++;
    end while (done !== 1'b1 && n < 60);
    check(n < 60, 1);
  endtask
  task finish_test;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 0;
    @(posedge mclk_in);
    apb(0, OFF_CTRL, 0);
    check(q, RST_CTRL);
    apb(0, 8'h1c, 0);
    check(e, 1);
    run(fy(RS_SUM_ONE, 1, 6'h34), 24'hf2_3456, 1);
    view(5'h0a, 32'h00ff_ffff);
    view(5'h08, 32'h0000_0000);
    view(RS_SUM_ONE, 32'h00f2_3456);
    check(limit, 0);
    run(fy(5'h0a, 1, 6'h34), 24'h00_0001, 1);
    run(fy(RS_SUM_ONE, 0, 6'h20), 0, 0);
    check(prog_mem_inst.dmem[0], SAT_POS);
    check(limit, 1);
    check(msp, 1);
    run(fy(5'h0a, 1, 6'h34), 24'h00_00fe, 1);
    run(fy(RS_SUM_ONE, 0, 6'h20), 0, 0);
    check(prog_mem_inst.dmem[0], SAT_NEG);
    apb(1, OFF_MASK, 1);
    repeat (2) @(posedge mclk_in);
    check(irq, 1);
    apb(1, OFF_STATUS, 1);
    repeat (2) @(posedge mclk_in);
    check(irq, 0);
    run(fy(5'h10, 1, 6'h34), 24'hab_3456, 1);
    run(fy(5'h10, 0, 6'h21), 0, 0);
    check(prog_mem_inst.dmem[0], 0);
    run(fy(5'h10, 0, 6'h21), 0, 0);
    check(prog_mem_inst.dmem[0], 24'h00_3456);
    prog_mem_inst.dmem[6'h16] = 24'h5a_5a5a;
    run(fy(RS_INPUT_ONE_LOW, 1, 6'h18), 0, 0);
    view(RS_INPUT_ONE_LOW, 32'h005a_5a5a);
    view(5'h10, 32'h0000_3457);
    // class II: limited first accumulator out, first input register back in
    run(24'h08_2000, 0, 0);
    check(prog_mem_inst.dmem[6'h17], SAT_NEG);
    check(msp, 0);
    view(RS_SUM_ONE, 32'h005a_5a5a);
    // class II with the absolute code is refused
    run(24'h08_3000, 0, 0);
    apb(0, OFF_STATUS, 0);
    check(q[ST_ILLEGAL], 1);
    // short form store of the first input register to address five
    run(fy(RS_INPUT_ONE_LOW, 0, 6'h05) & 24'hff_bfff, 0, 0);
    check(prog_mem_inst.dmem[5], 24'h5a_5a5a);
    // accumulator copied to an input register, third input stored pre-decremented
    run(24'h11_7900, 0, 0);
    view(5'h05, 32'h005a_5a5a);
    view(5'h11, 32'h0000_ffff);
    check(prog_mem_inst.dmem[6'h3f], 0);
    finish_test;
  end
endmodule
`default_nettype wire
